// File: logic/limit_compare.sv
`timescale 1ns/100ps
`default_nettype none
module limit_compare
   import queue_watermark_pkg::*;
(
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // Count and limit
   input  wire logic [COUNT_W-1:0] count,
   input  wire logic [LIMIT_W-1:0] limit,
   // Registered result
   output logic                    hit
);
   logic next_hit;

   always_comb begin
      next_hit = (limit != LIMIT_DISABLE) && ({3'h0, count} >= {3'h0, limit});
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hit <= 1'b0;
      end else begin
         hit <= next_hit;
      end
   end
endmodule : limit_compare
`default_nettype wire

// File: logic/queue_watermark_pkg.sv
package queue_watermark_pkg;

   // Register byte addresses, compared directly with reg_addr, one register every four bytes
   localparam logic [7:0]  ADDR_LIMITS      = 8'h00;
   localparam logic [7:0]  ADDR_STATUS      = 8'h04;
   localparam logic [7:0]  ADDR_INT_STATUS  = 8'h08;
   localparam logic [7:0]  ADDR_INT_MASK    = 8'h0c;

   // Limit register field positions
   localparam int          LIMIT_FOUR_LSB   = 0;
   localparam int          LIMIT_FIVE_LSB   = 8;
   localparam int          LIMIT_W          = 5;
   localparam logic [4:0]  LIMIT_RESET      = 5'h10;
   localparam logic [4:0]  LIMIT_DISABLE    = 5'h11;

   // Status register field positions
   localparam int          STAT_BUSY_BIT    = 4;
   localparam int          STAT_COMP_LSB    = 8;
   localparam int          STAT_QUEUE_LSB   = 16;
   localparam logic [5:0]  COMP_MAX         = 6'h3f;
   localparam logic [31:0] STATUS_RESET     = 32'h0000_0000;

   // Interrupt bits: 0 queue four limit hit, 1 queue five limit hit, 2 completion count full
   localparam int          INT_W            = 3;

   localparam int          NUM_QUEUES       = 6;
   localparam int          COUNT_W          = 5;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef struct packed {
      logic       submit_with_completion;
      logic       completion_return;
   } completion_evt_t;

endpackage : queue_watermark_pkg

// File: logic/queue_watermark_status.sv
`timescale 1ns/100ps
`default_nettype none
module queue_watermark_status
   import queue_watermark_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // Register port
   input  wire logic [7:0]             reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [31:0]                 reg_rdata,
   // Queue entry counts, queues 0..5
   input  wire logic [NUM_QUEUES*COUNT_W-1:0] queue_entry_count,
   // Other activity sources of the controller, bits 3..0
   input  wire logic [3:0]             unit_active,
   // Completion tracking
   input  wire logic                   submit_with_completion,
   input  wire logic                   completion_return,
   output logic                        request_stall,
   // Limit hit flags towards error and queue status registers
   output logic                        err_limit_hit_a,
   output logic                        err_limit_hit_b,
   output logic                        queue_four_status_hit,
   output logic                        queue_five_status_hit,
   // Interrupt
   output logic                        irq
);
   reg_req_t        req;
   completion_evt_t cevt;
   logic [LIMIT_W-1:0] limit_queue_four;
   logic [LIMIT_W-1:0] limit_queue_five;
   logic [LIMIT_W-1:0] next_limit_queue_four;
   logic [LIMIT_W-1:0] next_limit_queue_five;
   logic [5:0]         pending_completion_count;
   logic [5:0]         next_pending_completion_count;
   logic [NUM_QUEUES-1:0] queue_nonempty;
   logic [NUM_QUEUES-1:0] next_queue_nonempty;
   logic               controller_busy;
   logic               next_controller_busy;
   logic [3:0]         unit_active_q;
   logic [INT_W-1:0]   int_status;
   logic [INT_W-1:0]   next_int_status;
   logic [INT_W-1:0]   int_mask;
   logic [INT_W-1:0]   next_int_mask;
   logic [31:0]        next_rdata;
   logic               next_stall;
   logic               next_irq;
   logic               hit_four;
   logic               hit_five;
   logic               hit_four_d;
   logic               hit_five_d;
   logic [31:0]        status_word;
   logic [31:0]        limits_word;

   assign req  = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   assign cevt = '{submit_with_completion: submit_with_completion, completion_return: completion_return};

   // Queue four limit, queue five limit
   limit_compare u_cmp_four (
      .clk   (clk),
      .rst_n (rst_n),
      .count (queue_entry_count[4*COUNT_W +: COUNT_W]),
      .limit (limit_queue_four),
      .hit   (hit_four)
   );
   limit_compare u_cmp_five (
      .clk   (clk),
      .rst_n (rst_n),
      .count (queue_entry_count[5*COUNT_W +: COUNT_W]),
      .limit (limit_queue_five),
      .hit   (hit_five)
   );

   // Limit register; out-of-range codes are stored as written, software must avoid them
   always_comb begin
      next_limit_queue_four = limit_queue_four;
      next_limit_queue_five = limit_queue_five;
      if (req.wr && req.addr == ADDR_LIMITS) begin
         next_limit_queue_four = req.wdata[LIMIT_FOUR_LSB +: LIMIT_W];
         next_limit_queue_five = req.wdata[LIMIT_FIVE_LSB +: LIMIT_W];
      end
   end

   // A write to the limit register lands on the next edge, anything else leaves it alone
   AST_LIMIT_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(rst_n) && $past(reg_wr) && $past(reg_addr) == ADDR_LIMITS)
      |-> limit_queue_four == $past(reg_wdata[4:0]) && limit_queue_five == $past(reg_wdata[12:8]))
      else $error("limit register write not taken");
   AST_LIMIT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(rst_n) && !($past(reg_wr) && $past(reg_addr) == ADDR_LIMITS))
      |-> $stable(limit_queue_four) && $stable(limit_queue_five))
      else $error("limit register changed without a write");

   // Per-queue nonempty bits
   genvar q;
   generate
      for (q = 0; q < NUM_QUEUES; q++) begin : g_queue
         assign next_queue_nonempty[q] = |queue_entry_count[q*COUNT_W +: COUNT_W];
         AST_NONEMPTY_EACH: assert property (@(posedge clk) disable iff (!rst_n)
            $past(rst_n) |-> queue_nonempty[q] == ($past(queue_entry_count[q*COUNT_W +: COUNT_W]) != 5'h00))
            else $error("queue nonempty bit differs from its count");
      end
   endgenerate

   // Completion counter: simultaneous submit and return cancel out
   always_comb begin
      next_pending_completion_count = pending_completion_count;
      if (cevt.submit_with_completion && !cevt.completion_return && pending_completion_count != COMP_MAX) begin
         next_pending_completion_count = pending_completion_count + 6'h01;
      end else if (!cevt.submit_with_completion && cevt.completion_return && pending_completion_count != 6'h00) begin
         next_pending_completion_count = pending_completion_count - 6'h01;
      end
      next_stall = (next_pending_completion_count == COMP_MAX);
   end

   AST_COMP_UP: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(rst_n) && $past(submit_with_completion && !completion_return && pending_completion_count != COMP_MAX))
      |-> pending_completion_count == $past(pending_completion_count) + 6'h01)
      else $error("completion count did not count up");
   AST_COMP_DOWN: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(rst_n) && $past(!submit_with_completion && completion_return && pending_completion_count != 6'h00))
      |-> pending_completion_count == $past(pending_completion_count) - 6'h01)
      else $error("completion count did not count down");
   // A full counter must not wrap, or the stall would drop with work still outstanding
   AST_COMP_FULL: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(rst_n) && $past(pending_completion_count == COMP_MAX && submit_with_completion && !completion_return))
      |-> pending_completion_count == COMP_MAX && request_stall)
      else $error("full completion count wrapped or released the stall");
   AST_COMP_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(rst_n) && $past(submit_with_completion == completion_return)) |-> $stable(pending_completion_count))
      else $error("completion count moved without a lone event");

   always_comb begin
      next_controller_busy = (|next_queue_nonempty) || (|unit_active) || (next_pending_completion_count != 6'h00);
   end

   AST_BUSY_EXACT: assert property (@(posedge clk) disable iff (!rst_n)
      controller_busy == ((|queue_nonempty) || (|unit_active_q) || (pending_completion_count != 6'h00)))
      else $error("busy bit is not the OR of the activity bits");

   // Status words
   always_comb begin
      status_word = STATUS_RESET;
      status_word[STAT_QUEUE_LSB +: NUM_QUEUES] = queue_nonempty;
      status_word[STAT_COMP_LSB +: 6] = pending_completion_count;
      status_word[STAT_BUSY_BIT] = controller_busy;
      status_word[3:0] = unit_active_q;
      limits_word = 32'h0000_0000;
      limits_word[LIMIT_FOUR_LSB +: LIMIT_W] = limit_queue_four;
      limits_word[LIMIT_FIVE_LSB +: LIMIT_W] = limit_queue_five;
   end

   AST_STATUS_READ: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(rst_n) && $past(reg_rd) && $past(reg_addr) == ADDR_STATUS)
      |-> reg_rdata[21:16] == $past(queue_nonempty) && reg_rdata[13:8] == $past(pending_completion_count)
      && reg_rdata[4] == $past(controller_busy) && reg_rdata[3:0] == $past(unit_active_q))
      else $error("status read does not show live activity");

   // Interrupts: set wins over write-one-to-clear
   always_comb begin
      next_int_status = int_status;
      next_int_mask   = int_mask;
      if (req.wr && req.addr == ADDR_INT_STATUS) begin
         next_int_status = int_status & ~req.wdata[INT_W-1:0];
      end
      if (req.wr && req.addr == ADDR_INT_MASK) begin
         next_int_mask = req.wdata[INT_W-1:0];
      end
      if (hit_four && !hit_four_d) begin
         next_int_status[0] = 1'b1;
      end
      if (hit_five && !hit_five_d) begin
         next_int_status[1] = 1'b1;
      end
      if (next_stall && !request_stall) begin
         next_int_status[2] = 1'b1;
      end
      next_irq = |(next_int_status & next_int_mask);
   end

   // Each limit hit edge and the counter filling up must leave a sticky bit behind
   AST_INT_FOUR: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(rst_n) && $past(hit_four && !hit_four_d)) |-> int_status[0])
      else $error("queue four limit event not latched");
   AST_INT_FIVE: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(rst_n) && $past(hit_five && !hit_five_d)) |-> int_status[1])
      else $error("queue five limit event not latched");
   AST_INT_FULL: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(rst_n) && $past(next_stall && !request_stall)) |-> int_status[2])
      else $error("completion full event not latched");

   // Read mux, unmapped addresses read zero; status ignores writes
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (req.rd) begin
         case (req.addr)
            ADDR_LIMITS:     next_rdata = limits_word;
            ADDR_STATUS:     next_rdata = status_word;
            ADDR_INT_STATUS: next_rdata = {29'h0, int_status};
            ADDR_INT_MASK:   next_rdata = {29'h0, int_mask};
            default:         next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         limit_queue_four         <= LIMIT_RESET;
         limit_queue_five         <= LIMIT_RESET;
         pending_completion_count <= 6'h00;
         queue_nonempty           <= 6'h00;
         controller_busy          <= 1'b0;
         unit_active_q            <= 4'h0;
         int_status               <= 3'h0;
         int_mask                 <= 3'h0;
         reg_rdata                <= 32'h0000_0000;
         request_stall            <= 1'b0;
         irq                      <= 1'b0;
         hit_four_d               <= 1'b0;
         hit_five_d               <= 1'b0;
         err_limit_hit_a          <= 1'b0;
         err_limit_hit_b          <= 1'b0;
         queue_four_status_hit    <= 1'b0;
         queue_five_status_hit    <= 1'b0;
      end else begin
         limit_queue_four         <= next_limit_queue_four;
         limit_queue_five         <= next_limit_queue_five;
         pending_completion_count <= next_pending_completion_count;
         queue_nonempty           <= next_queue_nonempty;
         controller_busy          <= next_controller_busy;
         unit_active_q            <= unit_active;
         int_status               <= next_int_status;
         int_mask                 <= next_int_mask;
         reg_rdata                <= next_rdata;
         request_stall            <= next_stall;
         irq                      <= next_irq;
         hit_four_d               <= hit_four;
         hit_five_d               <= hit_five;
         err_limit_hit_a          <= hit_four;
         err_limit_hit_b          <= hit_five;
         queue_four_status_hit    <= hit_four;
         queue_five_status_hit    <= hit_five;
      end
   end

   // Checks
   AST_HIT_FIVE: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(queue_entry_count[5*COUNT_W +: COUNT_W], 2) >= $past(limit_queue_five, 2)
       && $past(limit_queue_five, 2) != LIMIT_DISABLE && $past(rst_n, 2)) |-> err_limit_hit_b)
      else $error("queue five limit hit flag missing");
   AST_HIT_FOUR: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(queue_entry_count[4*COUNT_W +: COUNT_W], 2) >= $past(limit_queue_four, 2)
       && $past(limit_queue_four, 2) != LIMIT_DISABLE && $past(rst_n, 2)) |-> err_limit_hit_a)
      else $error("queue four limit hit flag missing");
   AST_STATUS_MATCH: assert property (@(posedge clk) disable iff (!rst_n)
      (queue_four_status_hit == err_limit_hit_a) && (queue_five_status_hit == err_limit_hit_b))
      else $error("queue status hit differs from error flag");
   // Status flags are checked both ways, so a stuck-high flag is caught as well
   AST_STATUS_FOUR: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(rst_n) && $past(rst_n, 2)) |-> queue_four_status_hit == ($past(queue_entry_count[4*COUNT_W +: COUNT_W], 2)
      >= $past(limit_queue_four, 2) && $past(limit_queue_four, 2) != LIMIT_DISABLE))
      else $error("queue four status hit wrong");
   AST_STATUS_FIVE: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(rst_n) && $past(rst_n, 2)) |-> queue_five_status_hit == ($past(queue_entry_count[5*COUNT_W +: COUNT_W], 2)
      >= $past(limit_queue_five, 2) && $past(limit_queue_five, 2) != LIMIT_DISABLE))
      else $error("queue five status hit wrong");
   AST_DISABLE: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(limit_queue_five, 2) == LIMIT_DISABLE && $past(rst_n, 2)) |-> !err_limit_hit_b)
      else $error("disabled limit still flags");
   AST_DISABLE_FOUR: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(limit_queue_four, 2) == LIMIT_DISABLE && $past(rst_n, 2)) |-> !err_limit_hit_a)
      else $error("disabled queue four limit still flags");
   AST_RESERVED: assert property (@(posedge clk) disable iff (!rst_n)
      $past(reg_rd) && $past(reg_addr) == ADDR_STATUS |-> reg_rdata[31:22] == 10'h0
      && reg_rdata[15:14] == 2'h0 && reg_rdata[7:5] == 3'h0)
      else $error("status reserved bits not zero");
   AST_NONEMPTY: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> queue_nonempty[0] == ($past(queue_entry_count[COUNT_W-1:0]) != 5'h00))
      else $error("queue nonempty bit wrong");
   AST_STALL: assert property (@(posedge clk) disable iff (!rst_n)
      request_stall == (pending_completion_count == COMP_MAX))
      else $error("stall does not follow count of 63");
   AST_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
      (|queue_nonempty) |-> controller_busy)
      else $error("busy low while a queue holds work");
   AST_LIMIT_RSV: assert property (@(posedge clk) disable iff (!rst_n)
      $past(reg_rd) && $past(reg_addr) == ADDR_LIMITS |-> reg_rdata[31:13] == 19'h0
      && reg_rdata[7:5] == 3'h0)
      else $error("limit reserved bits not zero");
endmodule : queue_watermark_status
`default_nettype wire

// File: test/dma_queue_watermark_status_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin errors++; \
   $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module dma_queue_watermark_status_tb
   import queue_watermark_pkg::*;
;
   logic                           clk = 1'b0;
   logic                           rst_n = 1'b0;
   logic [7:0]                     reg_addr = 8'h00;
   logic [31:0]                    reg_wdata = 32'h0;
   logic                           reg_wr = 1'b0;
   logic                           reg_rd = 1'b0;
   logic [31:0]                    reg_rdata;
   logic [NUM_QUEUES*COUNT_W-1:0]  queue_entry_count = '0;
   logic [3:0]                     unit_active = 4'h0;
   logic                           submit_with_completion = 1'b0;
   logic                           completion_return = 1'b0;
   logic                           request_stall, err_limit_hit_a, err_limit_hit_b;
   logic                           queue_four_status_hit, queue_five_status_hit, irq;
   logic [31:0]                    rv;
   int                             errors = 0;
   int                             num_checks = 0;

   queue_watermark_status uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .queue_entry_count(queue_entry_count),
      .unit_active(unit_active), .submit_with_completion(submit_with_completion),
      .completion_return(completion_return), .request_stall(request_stall),
      .err_limit_hit_a(err_limit_hit_a), .err_limit_hit_b(err_limit_hit_b),
      .queue_four_status_hit(queue_four_status_hit), .queue_five_status_hit(queue_five_status_hit), .irq(irq));

   always #10 clk = ~clk;

   task automatic report_and_stop;
      if (errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe, so it is taken just past that edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   // Sets queue four and five counts and waits past the two-cycle compare latency
   task automatic counts(input logic [4:0] c4, input logic [4:0] c5, input logic ea, input logic eb);
      @(posedge clk);
      queue_entry_count[4*COUNT_W +: COUNT_W] <= c4;
      queue_entry_count[5*COUNT_W +: COUNT_W] <= c5;
      repeat (3) @(posedge clk);
      #1;
      `CHK("hit_a", ea, err_limit_hit_a)
      `CHK("four_status_hit", ea, queue_four_status_hit)
      `CHK("hit_b", eb, err_limit_hit_b)
      `CHK("five_status_hit", eb, queue_five_status_hit)
   endtask : counts

   task automatic pulse(input logic ret, input int n);
      @(posedge clk);
      submit_with_completion <= ~ret;
      completion_return      <= ret;
      repeat (n) @(posedge clk);
      submit_with_completion <= 1'b0;
      completion_return      <= 1'b0;
      @(posedge clk);
      #1;
   endtask : pulse

   task automatic t_reset;
      rd(ADDR_LIMITS, rv);
      `CHK("limits_reset", 32'h0000_1010, rv)
      rd(ADDR_STATUS, rv);
      `CHK("status_reset", 32'h0000_0000, rv)
   endtask : t_reset

   task automatic t_limits;
      wr(ADDR_LIMITS, 32'hffff_e3e5);
      rd(ADDR_LIMITS, rv);
      `CHK("limits_reserved", 32'h0000_0305, rv)
      counts(5'h04, 5'h02, 1'b0, 1'b0);
      counts(5'h05, 5'h03, 1'b1, 1'b1);
      counts(5'h1f, 5'h02, 1'b1, 1'b0);
      counts(5'h04, 5'h03, 1'b0, 1'b1);
   endtask : t_limits

   task automatic t_codes;
      wr(ADDR_LIMITS, 32'h0000_1111);
      counts(5'h1f, 5'h1f, 1'b0, 1'b0);
      wr(ADDR_LIMITS, 32'h0000_0000);
      counts(5'h00, 5'h00, 1'b1, 1'b1);
      wr(ADDR_LIMITS, 32'h0000_1010);
      counts(5'h10, 5'h0f, 1'b1, 1'b0);
      counts(5'h00, 5'h00, 1'b0, 1'b0);
   endtask : t_codes

   task automatic t_status;
      @(posedge clk);
      queue_entry_count <= {5'h09, 5'h00, 5'h00, 5'h02, 5'h00, 5'h01};
      unit_active       <= 4'ha;
      wr(ADDR_STATUS, 32'hffff_ffff);
      rd(ADDR_STATUS, rv);
      `CHK("status_live", 32'h0025_001a, rv)
      @(posedge clk);
      queue_entry_count <= '0;
      unit_active       <= 4'h0;
      repeat (2) @(posedge clk);
      rd(ADDR_STATUS, rv);
      `CHK("status_idle", 32'h0000_0000, rv)
      rd(8'h10, rv);
      `CHK("unmapped_read", 32'h0000_0000, rv)
   endtask : t_status

   task automatic t_completion;
      pulse(1'b0, 62);
      `CHK("stall_62", 1'b0, request_stall)
      pulse(1'b0, 1);
      `CHK("stall_63", 1'b1, request_stall)
      pulse(1'b0, 2);
      rd(ADDR_STATUS, rv);
      `CHK("count_saturated", 32'h0000_3f10, rv)
      pulse(1'b1, 1);
      `CHK("stall_released", 1'b0, request_stall)
      rd(ADDR_STATUS, rv);
      `CHK("count_62", 32'h0000_3e10, rv)
      pulse(1'b1, 62);
      rd(ADDR_STATUS, rv);
      `CHK("count_empty", 32'h0000_0000, rv)
   endtask : t_completion

   task automatic t_irq;
      rd(ADDR_INT_STATUS, rv);
      `CHK("int_status", 32'h0000_0007, rv)
      `CHK("irq_masked", 1'b0, irq)
      wr(ADDR_INT_MASK, 32'h0000_0002);
      @(posedge clk);
      #1;
      `CHK("irq_on", 1'b1, irq)
      wr(ADDR_INT_STATUS, 32'h0000_0002);
      @(posedge clk);
      #1;
      `CHK("irq_off", 1'b0, irq)
      rd(ADDR_INT_STATUS, rv);
      `CHK("int_cleared", 32'h0000_0005, rv)
   endtask : t_irq

   // Guards against a hang anywhere in the sequence
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      report_and_stop();
   end

   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_limits();
      t_codes();
      t_status();
      t_completion();
      t_irq();
      report_and_stop();
   end
endmodule : dma_queue_watermark_status_tb
`default_nettype wire
